// File: pkg/adc_seq_pkg.sv
package adc_seq_pkg;

  // ----------------------------------------------------------------
  // Register map and bus widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam logic [7:0]  REG_SAMPLE = 8'h00;   // Raw converter code, written by software.
  localparam logic [7:0]  REG_STATUS = 8'h04;   // Sequencer state, read only.
  localparam logic [15:0] SAMPLE_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Control byte layout, start bit first on the wire
  // ----------------------------------------------------------------
  localparam int unsigned CB_RANGE   = 6;       // One selects unipolar range.
  localparam int unsigned CB_EXTCLK  = 5;       // One selects the external conversion clock.
  localparam int unsigned CB_USER_LO = 0;       // Bits 2..0 drive the user outputs.
  localparam logic [15:0] BIPOLAR_FLIP = 16'h8000;

  // ----------------------------------------------------------------
  // Link timing, counted in serial clocks from the start bit (clock 1)
  // ----------------------------------------------------------------
  localparam logic [5:0] MODE_CNT       = 6'h04;  // Edge that brings in the low mode bit.
  localparam logic [5:0] ACQ_END_SHORT  = 6'h05;  // 5.5 clocks of acquisition.
  localparam logic [5:0] ACQ_END_LONG   = 6'h0D;  // 13.5 clocks of acquisition.
  localparam logic [5:0] CONV_CNT       = 6'h06;  // Edge after the seventh control bit.
  localparam logic [5:0] BYTE_CNT       = 6'h07;  // Edge that completes the control byte.
  localparam logic [5:0] LOAD_SHORT     = 6'h07;  // Result MSB driven for clock 9 of 24.
  localparam logic [5:0] LOAD_LONG      = 6'h0F;  // Result MSB driven for clock 17 of 32.
  localparam logic [5:0] LAST_SHORT     = 6'h17;  // Frame of 24 clocks ends here.
  localparam logic [5:0] LAST_LONG      = 6'h1F;  // Frame of 32 clocks ends here.
  localparam int         CAL_CYCLES_DEF = 80000;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic       RANGE_RST  = 1'b0;     // Bipolar.
  localparam logic       EXTCLK_RST = 1'b0;     // Internal clock.
  localparam logic [2:0] USER_RST   = 3'h0;

  typedef enum logic [1:0] {
    MODE_SHORT = 2'b00,
    MODE_CAL   = 2'b01,
    MODE_POWER_DOWN_PIN_N  = 2'b10,
    MODE_LONG  = 2'b11
  } mode_code_t;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_CAL     = 2'b01,
    ST_SWDOWN  = 2'b10,
    ST_PINDOWN = 2'b11
  } dev_state_t;

  typedef enum logic {
    LK_HUNT  = 1'b0,
    LK_FRAME = 1'b1
  } link_state_t;

endpackage

// File: core/adc_mode_seq.sv
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
// Behaviour
// - Mode code 00 gives short acquisition, 5.5 clocks, in a 24-clock frame.
// - Mode code 11 gives long acquisition, 13.5 clocks, in a 32-clock frame.
// - Mode code 01 launches self-calibration; only the serial command starts it.
// - A calibration lasts about 80,000 clock cycles unless aborted.
// - Reset pin low, power-down pin low or a new start bit aborts calibration.
// - Mode code 10 completes its conversion, then enters software power-down.
// - Software power-down ends when a new start bit arrives.
// - A power-down conversion reuses the previous acquisition length.
// - Power-down pin low shuts the device down, independent of software.
// - The control byte takes the first eight clocks; the result is shifted out only after them.
// - Unipolar results are straight binary, bipolar results two's complement.
// - First high bit sampled with chip select low is the start bit.
// - Conversion begins on the edge after the seventh control bit.
// - Reset clears user outputs, calibration state, selects bipolar and internal clock.
// - Results shift out most significant bit first.
module adc_mode_seq
  import adc_seq_pkg::*;
#(
  parameter int CAL_CYCLES = adc_seq_pkg::CAL_CYCLES_DEF
) (
  input  wire logic                             CLK,
  input  wire logic                             SRST,
  input  wire logic                             PSEL,
  input  wire logic                             PENABLE,
  input  wire logic                             PWRITE,
  input  wire logic [adc_seq_pkg::ADDR_W-1:0]   PADDR,
  input  wire logic [adc_seq_pkg::DATA_W-1:0]   PWDATA,
  output logic      [adc_seq_pkg::DATA_W-1:0]   PRDATA,
  output logic                                  PREADY,
  output logic                                  PSLVERR,
  input  wire logic                             SCLK,
  input  wire logic                             CS_N,
  input  wire logic                             DIN,
  output logic                                  DOUT,
  output logic                                  DOUT_OE,
  input  wire logic                             RST_PIN_N,
  input  wire logic                             POWER_DOWN_PIN_N,
  output logic      [2:0]                       USER_OUT,
  output logic                                  CAL_BUSY,
  output logic                                  POWERED_DOWN,
  output logic                                  ACQ_TRACK
);
  import adc_seq_pkg::*;

  localparam int CAL_W = 20;

  if (CAL_CYCLES < 2 || CAL_CYCLES >= (1 << CAL_W)) begin : g_bad_cal
    $error("CAL_CYCLES out of range for the calibration counter");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic              rstpin_s1_ff, rstpin_s2_ff, pwd_s1_ff, pwd_s2_ff;
  logic [2:0]        tgl_s1_ff, tgl_s2_ff, tgl_s3_ff;
  logic              start_ev, cmd_ev, done_ev, core_rst_ff;
  dev_state_t        state_ff, nxt_state;
  logic [CAL_W-1:0]  cal_cnt_ff;
  logic              power_down_pin_n_pend_ff, range_ff, extclk_ff, cal_valid_ff;
  logic [2:0]        user_ff;
  logic              cal_busy_ff, pwr_dn_ff;
  logic [15:0]       sample_ff;
  logic              smp_tgl_ff;
  logic [31:0]       prdata_ff;
  logic              pready_ff, pslverr_ff;
  mode_code_t        cmd_mode;
  // Link domain.
  logic              lrst_s1_ff, lrst_s2_ff;
  logic              smp_s1_ff, smp_s2_ff, smp_s3_ff;
  logic [15:0]       sample_lnk_ff, held_ff, shift_ff;
  link_state_t       lstate_ff;
  logic [5:0]        cnt_ff;
  logic [6:0]        ctrl_ff;
  logic [7:0]        cmd_byte_ff;
  mode_code_t        mode_ff;
  logic              long_ff, last_long_ff, cs_seen_ff, acq_ff, dout_ff, dout_oe_ff;
  logic              start_tgl_ff, cmd_tgl_ff, done_tgl_ff;
  logic              start_now, restart, in_frame;
  mode_code_t        new_code;
  logic [5:0]        load_cnt, last_cnt;

  // ----------------------------------------------------------------
  // Pin and event synchronisers into the core clock
  // ----------------------------------------------------------------

  // Pins idle high so an unconnected board does not hold the device down.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      rstpin_s1_ff <= 1'b1;
      rstpin_s2_ff <= 1'b1;
      pwd_s1_ff    <= 1'b1;
      pwd_s2_ff    <= 1'b1;
    end else begin
      rstpin_s1_ff <= RST_PIN_N;
      rstpin_s2_ff <= rstpin_s1_ff;
      pwd_s1_ff    <= POWER_DOWN_PIN_N;
      pwd_s2_ff    <= pwd_s1_ff;
    end
  end

  // Link events travel as toggles; the third stage only feeds the edge detect.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      tgl_s1_ff <= 3'h0;
      tgl_s2_ff <= 3'h0;
      tgl_s3_ff <= 3'h0;
    end else begin
      tgl_s1_ff <= {done_tgl_ff, cmd_tgl_ff, start_tgl_ff};
      tgl_s2_ff <= tgl_s1_ff;
      tgl_s3_ff <= tgl_s2_ff;
    end
  end

  assign start_ev = tgl_s2_ff[0] ^ tgl_s3_ff[0];
  assign cmd_ev   = tgl_s2_ff[1] ^ tgl_s3_ff[1];
  assign done_ev  = tgl_s2_ff[2] ^ tgl_s3_ff[2];
  // The command byte is held in the link domain until the next frame's byte,
  // which lies many serial clocks after the toggle, so it is stable here.
  assign cmd_mode = mode_code_t'(cmd_byte_ff[4:3]);

  // ----------------------------------------------------------------
  // Device state machine
  // ----------------------------------------------------------------

  // Pins outrank serial events; the reset pin outranks everything.
  always_comb begin
    nxt_state = state_ff;
    if (!rstpin_s2_ff) begin
      nxt_state = ST_IDLE;
    end else if (!pwd_s2_ff) begin
      nxt_state = ST_PINDOWN;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (cmd_ev && cmd_mode == MODE_CAL) begin
            nxt_state = ST_CAL;
          end else if (done_ev && power_down_pin_n_pend_ff) begin
            nxt_state = ST_SWDOWN;
          end
        end
        ST_CAL: begin
          if (start_ev || cal_cnt_ff == '0) begin
            nxt_state = ST_IDLE;
          end
        end
        ST_SWDOWN: begin
          if (start_ev) begin
            nxt_state = ST_IDLE;
          end
        end
        ST_PINDOWN: nxt_state = ST_IDLE;
        default:    nxt_state = ST_IDLE;
      endcase
    end
  end

  // State and the status outputs derived from it move together.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_ff    <= ST_IDLE;
      cal_busy_ff <= 1'b0;
      pwr_dn_ff   <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      cal_busy_ff <= (nxt_state == ST_CAL);
      pwr_dn_ff   <= nxt_state[1];
    end
  end

  // Calibration counter; it is reloaded on every entry.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      cal_cnt_ff <= '0;
    end else if (state_ff != ST_CAL) begin
      cal_cnt_ff <= CAL_W'(CAL_CYCLES - 1);
    end else if (cal_cnt_ff != '0) begin
      cal_cnt_ff <= cal_cnt_ff - CAL_W'(1);
    end
  end

  // A pending software power-down dies with a restarted frame; a new command wins.
  always_ff @(posedge CLK) begin
    if (SRST || !rstpin_s2_ff) begin
      power_down_pin_n_pend_ff <= 1'b0;
    end else if (cmd_ev) begin
      power_down_pin_n_pend_ff <= (cmd_mode == MODE_POWER_DOWN_PIN_N);
    end else if (done_ev || start_ev) begin
      power_down_pin_n_pend_ff <= 1'b0;
    end
  end

  // Configuration taken from each control byte, defaults on either reset.
  always_ff @(posedge CLK) begin
    if (SRST || !rstpin_s2_ff) begin
      range_ff     <= RANGE_RST;
      extclk_ff    <= EXTCLK_RST;
      user_ff      <= USER_RST;
      cal_valid_ff <= 1'b0;
    end else begin
      if (cmd_ev) begin
        range_ff  <= cmd_byte_ff[CB_RANGE];
        extclk_ff <= cmd_byte_ff[CB_EXTCLK];
        user_ff   <= cmd_byte_ff[CB_USER_LO +: 3];
      end
      if (state_ff == ST_CAL && nxt_state == ST_IDLE && !start_ev) begin
        cal_valid_ff <= 1'b1;
      end else if (cmd_ev && cmd_mode == MODE_CAL) begin
        cal_valid_ff <= 1'b0;
      end
    end
  end

  // Reset request for the link domain, registered before it crosses.
  always_ff @(posedge CLK) begin
    core_rst_ff <= SRST | ~rstpin_s2_ff;
  end

  // ----------------------------------------------------------------
  // APB slave: one wait state, errors on unmapped addresses
  // ----------------------------------------------------------------

  // The answer is prepared in the first access cycle and shown in the second.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= PSEL & PENABLE & ~pready_ff;
      pslverr_ff <= PSEL & PENABLE & ~pready_ff &
                    (PADDR != REG_SAMPLE) & (PADDR != REG_STATUS);
      prdata_ff  <= 32'h0000_0000;
      if (PSEL && PENABLE && !pready_ff && !PWRITE) begin
        if (PADDR == REG_SAMPLE) begin
          prdata_ff <= {16'h0000, sample_ff};
        end else if (PADDR == REG_STATUS) begin
          prdata_ff <= {15'h0000, power_down_pin_n_pend_ff, cal_valid_ff, user_ff, extclk_ff,
                        range_ff, state_ff, cmd_byte_ff};
        end
      end
    end
  end

  // The sample word is what the converter core would deliver; a toggle marks it.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      sample_ff  <= SAMPLE_RST;
      smp_tgl_ff <= 1'b0;
    end else if (PSEL && PENABLE && pready_ff && PWRITE && PADDR == REG_SAMPLE) begin
      sample_ff  <= PWDATA[15:0];
      smp_tgl_ff <= ~smp_tgl_ff;
    end
  end

  assign PRDATA       = prdata_ff;
  assign PREADY       = pready_ff;
  assign PSLVERR      = pslverr_ff;
  assign USER_OUT     = user_ff;
  assign CAL_BUSY     = cal_busy_ff;
  assign POWERED_DOWN = pwr_dn_ff;

  // ----------------------------------------------------------------
  // Link domain on the serial clock
  // ----------------------------------------------------------------

  // Reset and the sample toggle cross in; the serial clock may stop between
  // frames, so a reset is only seen once the master clocks again.
  always_ff @(posedge SCLK) begin
    lrst_s1_ff <= core_rst_ff;
    lrst_s2_ff <= lrst_s1_ff;
    smp_s1_ff  <= smp_tgl_ff;
    smp_s2_ff  <= smp_s1_ff;
    smp_s3_ff  <= smp_s2_ff;
  end

  // A new sample is captured once its toggle has settled.
  always_ff @(posedge SCLK) begin
    if (lrst_s2_ff) begin
      sample_lnk_ff <= SAMPLE_RST;
    end else if (smp_s2_ff ^ smp_s3_ff) begin
      sample_lnk_ff <= sample_ff;
    end
  end

  assign in_frame  = (lstate_ff == LK_FRAME);
  assign start_now = ~in_frame & ~CS_N & DIN;
  assign restart   = in_frame & cs_seen_ff & ~CS_N & DIN;
  assign new_code  = mode_code_t'({ctrl_ff[0], DIN});
  assign load_cnt  = long_ff ? LOAD_LONG : LOAD_SHORT;
  assign last_cnt  = long_ff ? LAST_LONG : LAST_SHORT;

  // Frame sequencing: hunt for the start bit, shift the control byte, clock data.
  always_ff @(posedge SCLK) begin
    if (lrst_s2_ff) begin
      lstate_ff    <= LK_HUNT;
      cnt_ff       <= 6'h00;
      ctrl_ff      <= 7'h00;
      mode_ff      <= MODE_SHORT;
      long_ff      <= 1'b0;
      last_long_ff <= 1'b0;
      cs_seen_ff   <= 1'b0;
      start_tgl_ff <= 1'b0;
      done_tgl_ff  <= 1'b0;
    end else if (start_now || restart) begin
      lstate_ff    <= LK_FRAME;
      cnt_ff       <= 6'h01;
      ctrl_ff      <= 7'h01;
      cs_seen_ff   <= 1'b0;
      start_tgl_ff <= ~start_tgl_ff;
    end else if (in_frame) begin
      cnt_ff     <= cnt_ff + 6'h01;
      cs_seen_ff <= cs_seen_ff | CS_N;
      if (cnt_ff < BYTE_CNT) begin
        ctrl_ff <= {ctrl_ff[5:0], DIN};
      end
      if (cnt_ff == MODE_CNT) begin
        mode_ff <= new_code;
        long_ff <= (new_code == MODE_LONG) || (new_code == MODE_POWER_DOWN_PIN_N && last_long_ff);
        if (new_code == MODE_SHORT || new_code == MODE_LONG) begin
          last_long_ff <= (new_code == MODE_LONG);
        end
      end
      if (cnt_ff == BYTE_CNT && mode_ff == MODE_CAL) begin
        lstate_ff <= LK_HUNT;
      end else if (cnt_ff == last_cnt) begin
        lstate_ff   <= LK_HUNT;
        done_tgl_ff <= ~done_tgl_ff;
      end
    end
  end

  // The full control byte is published with a toggle when its last bit lands.
  always_ff @(posedge SCLK) begin
    if (lrst_s2_ff) begin
      cmd_byte_ff <= 8'h00;
      cmd_tgl_ff  <= 1'b0;
    end else if (in_frame && !restart && cnt_ff == BYTE_CNT) begin
      cmd_byte_ff <= {ctrl_ff, DIN};
      cmd_tgl_ff  <= ~cmd_tgl_ff;
    end
  end

  // Acquisition window: open from the start bit to the mode's sampling edge.
  always_ff @(posedge SCLK) begin
    if (lrst_s2_ff) begin
      acq_ff <= 1'b0;
    end else if (start_now || restart) begin
      acq_ff <= 1'b1;
    end else if (!in_frame || (!long_ff && cnt_ff == ACQ_END_SHORT) ||
                 cnt_ff == ACQ_END_LONG) begin
      acq_ff <= 1'b0;
    end
  end

  // Conversion snapshot taken after the seventh bit, formatted by range.
  always_ff @(posedge SCLK) begin
    if (lrst_s2_ff) begin
      held_ff <= 16'h0000;
    end else if (in_frame && !restart && cnt_ff == CONV_CNT && mode_ff != MODE_CAL) begin
      held_ff <= ctrl_ff[4] ? sample_lnk_ff : (sample_lnk_ff ^ BIPOLAR_FLIP);
    end
  end

  // Result shifter, MSB first; data change on the edge after the master samples.
  always_ff @(posedge SCLK) begin
    if (lrst_s2_ff) begin
      shift_ff   <= 16'h0000;
      dout_ff    <= 1'b0;
      dout_oe_ff <= 1'b0;
    end else begin
      dout_oe_ff <= ~CS_N;
      if (!in_frame || restart || cnt_ff == last_cnt) begin
        shift_ff <= 16'h0000;
        dout_ff  <= 1'b0;
      end else if (cnt_ff == load_cnt && mode_ff != MODE_CAL) begin
        shift_ff <= {held_ff[14:0], 1'b0};
        dout_ff  <= held_ff[15];
      end else if (cnt_ff > load_cnt) begin
        shift_ff <= {shift_ff[14:0], 1'b0};
        dout_ff  <= shift_ff[15];
      end
    end
  end

  assign DOUT      = dout_ff;
  assign DOUT_OE   = dout_oe_ff;
  assign ACQ_TRACK = acq_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_cal_launch: assert property (@(posedge CLK) disable iff (SRST)
    (state_ff == ST_IDLE && cmd_ev && cmd_mode == MODE_CAL && rstpin_s2_ff && pwd_s2_ff)
    |=> (CAL_BUSY && state_ff == ST_CAL))
    else $error("Calibration command did not start calibration.");

  chk_cal_length: assert property (@(posedge CLK) disable iff (SRST)
    (state_ff == ST_CAL && cal_cnt_ff == CAL_W'(1) && !start_ev && rstpin_s2_ff && pwd_s2_ff)
    ##1 (!start_ev && rstpin_s2_ff && pwd_s2_ff) |=> (state_ff == ST_IDLE && cal_valid_ff))
    else $error("Calibration did not end when its count ran out.");

  chk_cal_abort: assert property (@(posedge CLK) disable iff (SRST)
    (state_ff == ST_CAL && (start_ev || !rstpin_s2_ff || !pwd_s2_ff))
    |=> (state_ff != ST_CAL && !CAL_BUSY))
    else $error("Calibration was not aborted.");

  chk_swdown_entry: assert property (@(posedge CLK) disable iff (SRST)
    (state_ff == ST_IDLE && power_down_pin_n_pend_ff && done_ev && !cmd_ev && rstpin_s2_ff && pwd_s2_ff)
    |=> (state_ff == ST_SWDOWN && POWERED_DOWN))
    else $error("Software power-down not entered after the conversion.");

  chk_swdown_wake: assert property (@(posedge CLK) disable iff (SRST)
    (state_ff == ST_SWDOWN && start_ev && rstpin_s2_ff && pwd_s2_ff)
    |=> (state_ff == ST_IDLE && !POWERED_DOWN))
    else $error("Start bit did not wake the device.");

  chk_pin_down: assert property (@(posedge CLK) disable iff (SRST)
    (!pwd_s2_ff && rstpin_s2_ff) [*2] |-> (POWERED_DOWN && state_ff == ST_PINDOWN))
    else $error("Power-down pin did not shut the device down.");

  chk_pin_reset: assert property (@(posedge CLK) disable iff (SRST)
    !rstpin_s2_ff |=> (USER_OUT == 3'h0 && !range_ff && !extclk_ff && !cal_valid_ff))
    else $error("Reset pin did not restore defaults.");

  chk_short_frame: assert property (@(posedge SCLK) disable iff (lrst_s2_ff)
    (in_frame && !restart && cnt_ff == MODE_CNT && new_code == MODE_SHORT)
    |=> !long_ff ##1 !ACQ_TRACK)
    else $error("Short acquisition window wrong.");

  chk_long_frame: assert property (@(posedge SCLK) disable iff (lrst_s2_ff)
    (in_frame && !restart && cnt_ff == MODE_CNT && new_code == MODE_LONG && !CS_N)
    ##1 (!restart && in_frame) [*8] |=> ACQ_TRACK ##1 !ACQ_TRACK)
    else $error("Long acquisition window wrong.");

  chk_reuse_length: assert property (@(posedge SCLK) disable iff (lrst_s2_ff)
    (in_frame && !restart && cnt_ff == MODE_CNT && new_code == MODE_POWER_DOWN_PIN_N)
    |=> (long_ff == $past(last_long_ff)))
    else $error("Power-down conversion changed acquisition length.");

  chk_start_bit: assert property (@(posedge SCLK) disable iff (lrst_s2_ff)
    (!in_frame && !CS_N && DIN) |=> (in_frame && cnt_ff == 6'h01 && ACQ_TRACK))
    else $error("Start bit not recognised.");

  chk_msb_first: assert property (@(posedge SCLK) disable iff (lrst_s2_ff)
    (in_frame && !restart && cnt_ff == load_cnt && mode_ff != MODE_CAL)
    |=> (DOUT == $past(held_ff[15])) ##1 (DOUT == $past(held_ff[14], 2)))
    else $error("Result not shifted MSB first.");

endmodule

// File: dv/serial_master.sv
`timescale 1ns/1ps
// -------------------------------------------------
// Serial master: the link clock runs only in frames and in warm-up bursts.
// -------------------------------------------------
module serial_master (
  output logic      SCLK,
  output logic      CS_N,
  output logic      DIN,
  input  wire logic DOUT
);
  initial begin
    SCLK = 1'b0;
    CS_N = 1'b1;
    DIN  = 1'b0;
  end
  // Clocks with chip select high let the link-side reset finish.
  task automatic warm(input int n);
    repeat (n) begin
      #32 SCLK = 1'b1;
      #32 SCLK = 1'b0;
    end
  endtask
  // Control byte out first, result taken MSB first just before each rise.
  task automatic frame(input logic [7:0] ctl, input int n, output logic [15:0] res);
    res = 16'h0000;
    #13 CS_N = 1'b0;
    for (int i = 1; i <= n; i++) begin
      DIN = (i <= 8) ? ctl[8-i] : 1'b0;
      #31;
      if (i > n - 16) res = {res[14:0], DOUT};
      #1 SCLK = 1'b1;
      #32 SCLK = 1'b0;
    end
    CS_N = 1'b1;
    DIN  = ~DIN; // Released line never keeps its last value.
  endtask
endmodule

// File: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import adc_seq_pkg::*;
  logic        clk, srst, psel, penable, pwrite, rst_pin_n, pd_pin_n, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, sclk, cs_n, din, dout, cal_busy, pwr_down, dout_oe;
  logic [2:0]  user_out;
  logic [15:0] res;
  int          fail_count = 0;
  int          n_compared = 0;
  int          k;
  adc_mode_seq #(.CAL_CYCLES(40)) u_dut (.CLK(clk), .SRST(srst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SCLK(sclk), .CS_N(cs_n), .DIN(din), .DOUT(dout),
    .DOUT_OE(dout_oe), .RST_PIN_N(rst_pin_n), .POWER_DOWN_PIN_N(pd_pin_n), .USER_OUT(user_out),
    .CAL_BUSY(cal_busy), .POWERED_DOWN(pwr_down), .ACQ_TRACK());
  serial_master u_master (.SCLK(sclk), .CS_N(cs_n), .DIN(din), .DOUT(dout));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // -------------------------------------------------
  // Shared tasks
  // -------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Negedge sampling keeps reads clear of the edge's own updates.
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask
  // One APB transfer; data and response are taken at the edge that samples ready high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
  endtask
  // Starts a calibration and lets it get under way.
  task automatic cal_start();
    // Calibration byte also sets range, external clock and user bits, so resets show.
    u_master.frame(8'hEB, 8, res);
    settle(6);
    check(cal_busy, 1'b1);
  endtask
  // -------------------------------------------------
  // Main sequence
  // -------------------------------------------------
  initial begin
    {srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {rst_pin_n, pd_pin_n} = 2'b11;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    u_master.warm(4);
    check(dout_oe, 1'b0);
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0);
    check(err, 1'b1);
    apb(1'b1, REG_SAMPLE, 32'h1234);
    settle(10);
    u_master.frame(8'h85, 24, res);
    check(res, 16'h1234 ^ BIPOLAR_FLIP);
    settle(10);
    check({dout_oe, user_out}, 4'hD);
    u_master.frame(8'hDE, 32, res);
    check(res, 16'h1234);
    u_master.frame(8'hD0, 32, res);
    check(res, 16'h1234);
    settle(10);
    check(pwr_down, 1'b1);
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd[9:0], 10'h2D0);
    u_master.frame(8'h85, 24, res);
    settle(10);
    check({pwr_down, res}, {1'b0, 16'h9234});
    $display("test conversions done");
    cal_start();
    settle(20);
    check(cal_busy, 1'b1);
    k = 0;
    while (cal_busy !== 1'b0 && k < 100) begin
      @(negedge clk);
      k++;
    end
    check(cal_busy, 1'b0);
    if (k == 100) print_verdict();
    cal_start();
    u_master.frame(8'h85, 24, res);
    settle(4);
    check(cal_busy, 1'b0);
    cal_start();
    @(posedge clk);
    pd_pin_n <= 1'b0;
    settle(5);
    check({cal_busy, pwr_down}, 2'b01);
    @(posedge clk);
    pd_pin_n <= 1'b1;
    settle(5);
    check(pwr_down, 1'b0);
    $display("test calibration done");
    cal_start();
    @(posedge clk);
    rst_pin_n <= 1'b0;
    settle(5);
    check({cal_busy, user_out}, 4'h0);
    @(posedge clk);
    rst_pin_n <= 1'b1;
    // Enough link clocks for the reset to cross in and be released again.
    u_master.warm(8);
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd, 32'h0);
    $display("test reset pin done");
    print_verdict();
  end
endmodule
